// >>> rtl/adc_mode_control_register.sv
// Function
// [R1] upper mode bits 00 run four independent channels, one core each
// [R2] codes 0100-0111 select two channels of two cores: AC, BC, AD, BD
// [R3] codes 1000-1011 select one channel of four cores on A, B, C or D
// [R4] codes 1100-1111 select common input sampling from A, B, C or D
// [R5] after reset the channel mode field holds 0000, four channels
// [R6] sleep 00 active and reset value, 11 full standby, 01 idles A,B
// [R7] sleep 10 idles C,D or active C/D; single or common modes fully idle
// [R8] bit 8 picks nominal bandwidth when 0, reset value, full when 1
// [R9] bit 12 switches output to the test pattern; clear by default
// [R10] address 0x01; mode bits 3:0, sleep 5:4, coding 7, bandwidth 8, test 12
// [R11] bit 7 picks binary coding when 0, reset value, Gray when 1
// [R12] host writes zero to bits 13 and 11; unused bits have no effect
// [R13] host supplies the alignment pulse whenever test mode is on
// [R14] pin reset or soft clear write returns the register to reset values
// [R15] frames start with a direction bit, 1 write; data 16 bits msb first
`timescale 1ns/1ps
`default_nettype none
module adc_mode_control_register
    import mode_ctrl_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // serial port pins
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    input wire logic serial_port_reset_n_i,
    output logic spi_miso_o,
    // decoded converter settings
    output logic [CH_N-1:0] group_mode_o,
    output logic [SEL_W-1:0] route_channel_o,
    output logic [1:0] cores_per_channel_o,
    output logic [CH_N-1:0] channel_active_o,
    output logic gray_code_o,
    output logic analog_bandwidth_select_o,
    output logic test_pattern_en_o
);
    // register fields
    logic [MODE_W-1:0] channel_interleave_select_q;
    logic [MODE_W-1:0] channel_interleave_select_d;
    logic [SLEEP_W-1:0] channel_sleep_select_q;
    logic [SLEEP_W-1:0] channel_sleep_select_d;
    logic gray_q, gray_d;
    logic analog_bandwidth_select_q, analog_bandwidth_select_d;
    logic test_en_q, test_en_d;
    // decoded outputs
    group_mode_e group_mode_q, group_mode_d;
    logic [SEL_W-1:0] route_q, route_d;
    logic [1:0] cores_q, cores_d;
    logic [CH_N-1:0] active_q, active_d;
    logic gray_out_q, gray_out_d;
    logic bw_out_q, bw_out_d;
    logic test_out_q, test_out_d;
    // combinational terms
    logic soft_config_clear;
    logic mode_write;
    logic [DATA_W-1:0] readback;
    logic [GROUP_W-1:0] group;
    logic [SEL_W-1:0] sel;
    logic [SLEEP_W-1:0] sleep;
    logic [CH_N-1:0] ab_pick, cd_pick, one_pick;

    reg_access_if acc ();

    spi_frame_rx u_rx (
        .clk_i (clk_i),
        .reset_i (reset_i),
        .sclk_i (spi_sclk_i),
        .cs_n_i (spi_cs_n_i),
        .mosi_i (spi_mosi_i),
        .rst_n_i (serial_port_reset_n_i),
        .miso_o (spi_miso_o),
        .bus (acc.link)
    );

    // register write path; reserved and unused bits are not stored
    always_comb begin
        soft_config_clear = acc.wr_valid && (acc.addr == SOFT_CLEAR_ADDR)
            && acc.wdata[SOFT_CLEAR_BIT];
        mode_write = acc.wr_valid && (acc.addr == MODE_CTRL_ADDR); // R10
        channel_interleave_select_d = channel_interleave_select_q;
        channel_sleep_select_d = channel_sleep_select_q;
        gray_d = gray_q;
        analog_bandwidth_select_d = analog_bandwidth_select_q;
        test_en_d = test_en_q;
        if (acc.pin_reset || soft_config_clear) begin
            channel_interleave_select_d = MODE_RESET; // R14 R5
            channel_sleep_select_d = SLEEP_RESET; // R14 R6
            gray_d = GRAY_RESET; // R14 R11
            analog_bandwidth_select_d = BW_RESET; // R14 R8
            test_en_d = TEST_RESET; // R14 R9
        end else if (mode_write) begin
            channel_interleave_select_d = acc.wdata[MODE_LSB +: MODE_W]; // R10
            channel_sleep_select_d = acc.wdata[SLEEP_LSB +: SLEEP_W]; // R10
            gray_d = acc.wdata[GRAY_BIT]; // R10
            analog_bandwidth_select_d = acc.wdata[BW_BIT]; // R10
            test_en_d = acc.wdata[TEST_BIT]; // R10
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            channel_interleave_select_q <= MODE_RESET; // R5
            channel_sleep_select_q <= SLEEP_RESET; // R6
            gray_q <= GRAY_RESET; // R11
            analog_bandwidth_select_q <= BW_RESET; // R8
            test_en_q <= TEST_RESET; // R9
        end else begin
            channel_interleave_select_q <= channel_interleave_select_d;
            channel_sleep_select_q <= channel_sleep_select_d;
            gray_q <= gray_d;
            analog_bandwidth_select_q <= analog_bandwidth_select_d;
            test_en_q <= test_en_d;
        end
    end

    // read path; the soft clear register always reads zero
    always_comb begin
        readback = '0;
        if (acc.addr == MODE_CTRL_ADDR) begin
            readback[MODE_LSB +: MODE_W] = channel_interleave_select_q; // R10
            readback[SLEEP_LSB +: SLEEP_W] = channel_sleep_select_q;
            readback[GRAY_BIT] = gray_q;
            readback[BW_BIT] = analog_bandwidth_select_q;
            readback[TEST_BIT] = test_en_q;
        end
    end

    assign acc.rdata = readback;

    // mode and standby decode, channel bit 0 is A through bit 3 is D
    always_comb begin
        group = channel_interleave_select_q[GROUP_LSB +: GROUP_W];
        sel = channel_interleave_select_q[SEL_LSB +: SEL_W];
        sleep = channel_sleep_select_q;
        ab_pick = {2'h0, sel[1'h0], ~sel[1'h0]};
        cd_pick = {sel[1'h1], ~sel[1'h1], 2'h0};
        one_pick = CH_A << sel;
        group_mode_d = MODE_FOUR;
        route_d = sel;
        cores_d = CORES_ONE;
        active_d = CH_NONE;
        case (group)
            GROUP_FOUR: begin
                group_mode_d = MODE_FOUR; // R1
                route_d = '0;
                cores_d = CORES_ONE; // R1
                case (sleep)
                    SLEEP_ACTIVE: active_d = CH_ALL; // R6
                    SLEEP_AB: active_d = CH_CD; // R6
                    SLEEP_CD: active_d = CH_AB; // R7
                    default: active_d = CH_NONE; // R6
                endcase
            end
            GROUP_TWO: begin
                group_mode_d = MODE_TWO; // R2
                cores_d = CORES_TWO; // R2
                case (sleep)
                    SLEEP_ACTIVE: active_d = ab_pick | cd_pick; // R2
                    SLEEP_AB: active_d = cd_pick; // R6
                    SLEEP_CD: active_d = ab_pick; // R7
                    default: active_d = CH_NONE; // R6
                endcase
            end
            GROUP_ONE: begin
                group_mode_d = MODE_ONE; // R3
                cores_d = CORES_FOUR; // R3
                // any standby code idles the single channel
                active_d = (sleep == SLEEP_ACTIVE) ? one_pick : CH_NONE; // R3 R7
            end
            default: begin
                // common input: every channel samples the chosen input
                group_mode_d = MODE_COMMON; // R4
                cores_d = CORES_ONE; // R4
                active_d = (sleep == SLEEP_ACTIVE) ? CH_ALL : CH_NONE; // R4 R7
            end
        endcase
        gray_out_d = gray_q; // R11
        bw_out_d = analog_bandwidth_select_q; // R8
        // alignment pulse is the host's duty while this is set
        test_out_d = test_en_q; // R9
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            group_mode_q <= MODE_FOUR;
            route_q <= '0;
            cores_q <= CORES_ONE;
            active_q <= CH_ALL;
            gray_out_q <= GRAY_RESET;
            bw_out_q <= BW_RESET;
            test_out_q <= TEST_RESET;
        end else begin
            group_mode_q <= group_mode_d;
            route_q <= route_d;
            cores_q <= cores_d;
            active_q <= active_d;
            gray_out_q <= gray_out_d;
            bw_out_q <= bw_out_d;
            test_out_q <= test_out_d;
        end
    end

    assign group_mode_o = group_mode_q;
    assign route_channel_o = route_q;
    assign cores_per_channel_o = cores_q;
    assign channel_active_o = active_q;
    assign gray_code_o = gray_out_q;
    assign analog_bandwidth_select_o = bw_out_q;
    assign test_pattern_en_o = test_out_q;

    AST_FOUR_CHANNEL: // R1
    assert property (@(posedge clk_i) disable iff (reset_i)
        (channel_interleave_select_q[GROUP_LSB +: GROUP_W] == GROUP_FOUR)
        |=> (group_mode_o == MODE_FOUR) && (cores_per_channel_o == CORES_ONE))
        else $error("four channel code did not give four single-core channels");

    AST_TWO_CHANNEL_PAIR: // R2
    assert property (@(posedge clk_i) disable iff (reset_i)
        (channel_interleave_select_q[GROUP_LSB +: GROUP_W] == GROUP_TWO
            && channel_sleep_select_q == SLEEP_ACTIVE)
        |=> (group_mode_o == MODE_TWO) && (cores_per_channel_o == CORES_TWO)
            && (channel_active_o == {$past(channel_interleave_select_q[1]),
                ~$past(channel_interleave_select_q[1]),
                $past(channel_interleave_select_q[0]),
                ~$past(channel_interleave_select_q[0])}))
        else $error("two channel pairing wrong");

    AST_ONE_CHANNEL: // R3
    assert property (@(posedge clk_i) disable iff (reset_i)
        (channel_interleave_select_q[GROUP_LSB +: GROUP_W] == GROUP_ONE
            && channel_sleep_select_q == SLEEP_ACTIVE)
        |=> (cores_per_channel_o == CORES_FOUR)
            && (channel_active_o == (CH_A << $past(channel_interleave_select_q[1:0]))))
        else $error("single channel output routed wrong");

    AST_COMMON_INPUT: // R4
    assert property (@(posedge clk_i) disable iff (reset_i)
        (channel_interleave_select_q[GROUP_LSB +: GROUP_W] == ~GROUP_FOUR)
        |=> (group_mode_o == MODE_COMMON)
            && (route_channel_o == $past(channel_interleave_select_q[1:0])))
        else $error("common input source wrong");

    AST_PIN_RESET_CLEARS: // R5 R14
    assert property (@(posedge clk_i) disable iff (reset_i)
        acc.pin_reset |=> (channel_interleave_select_q == MODE_RESET)
            ##1 (group_mode_o == MODE_FOUR) && (channel_active_o == CH_ALL)
            && !gray_code_o && !analog_bandwidth_select_o && !test_pattern_en_o)
        else $error("pin reset did not restore defaults");

    AST_SOFT_CLEAR: // R14
    assert property (@(posedge clk_i) disable iff (reset_i)
        soft_config_clear |-> ##2 (group_mode_o == MODE_FOUR)
            && (channel_active_o == CH_ALL) && !test_pattern_en_o
            && !gray_code_o && !analog_bandwidth_select_o)
        else $error("soft clear did not restore defaults");

    AST_SLEEP_FULL: // R6
    assert property (@(posedge clk_i) disable iff (reset_i)
        (channel_sleep_select_q == SLEEP_FULL) |=> (channel_active_o == CH_NONE))
        else $error("full standby left a channel active");

    AST_FOUR_SLEEP_AB: // R6
    assert property (@(posedge clk_i) disable iff (reset_i)
        (channel_interleave_select_q[GROUP_LSB +: GROUP_W] == GROUP_FOUR
            && channel_sleep_select_q == SLEEP_AB) |=> (channel_active_o == CH_CD))
        else $error("four channel standby of A and B wrong");

    AST_SINGLE_PARTIAL_SLEEP: // R7
    assert property (@(posedge clk_i) disable iff (reset_i)
        (channel_interleave_select_q[GROUP_LSB + 1] == 1'b1
            && (channel_sleep_select_q == SLEEP_AB || channel_sleep_select_q == SLEEP_CD))
        |=> (channel_active_o == CH_NONE))
        else $error("partial standby in single or common mode not full");

    AST_TWO_SLEEP_CD: // R7
    assert property (@(posedge clk_i) disable iff (reset_i)
        (channel_interleave_select_q[GROUP_LSB +: GROUP_W] == GROUP_TWO
            && channel_sleep_select_q == SLEEP_CD)
        |=> (channel_active_o[CH_N-1 -: 2] == 2'h0) && (channel_active_o != CH_NONE))
        else $error("two channel standby of C or D wrong");

    AST_BANDWIDTH_WRITE: // R8 R10
    assert property (@(posedge clk_i) disable iff (reset_i)
        (mode_write && !acc.pin_reset)
        |-> ##2 (analog_bandwidth_select_o == $past(acc.wdata[BW_BIT], 2)))
        else $error("bandwidth bit not taken from bit 8");

    AST_GRAY_WRITE: // R11 R10
    assert property (@(posedge clk_i) disable iff (reset_i)
        (mode_write && !acc.pin_reset)
        |-> ##2 (gray_code_o == $past(acc.wdata[GRAY_BIT], 2)))
        else $error("code format not taken from bit 7");

    AST_TEST_WRITE: // R9 R10
    assert property (@(posedge clk_i) disable iff (reset_i)
        (mode_write && !acc.pin_reset)
        |-> ##2 (test_pattern_en_o == $past(acc.wdata[TEST_BIT], 2)))
        else $error("test enable not taken from bit 12");
endmodule // adc_mode_control_register
`default_nettype wire

// >>> rtl/mode_ctrl_pkg.sv
package mode_ctrl_pkg;
    // serial frame: direction bit, address, data, msb first
    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;
    localparam int HEADER_BITS = 1 + ADDR_W;
    localparam int FRAME_BITS = HEADER_BITS + DATA_W;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [CNT_W-1:0] HEADER_LAST = 5'h07;
    localparam logic [CNT_W-1:0] HEADER_DONE = 5'h08;
    localparam logic [CNT_W-1:0] FRAME_LAST = 5'h17;
    localparam logic RW_READ = 1'b0;
    localparam logic RW_WRITE = 1'b1;
    // pin synchroniser lanes
    localparam int PIN_W = 4;
    localparam int PIN_SCLK = 0;
    localparam int PIN_CS_N = 1;
    localparam int PIN_MOSI = 2;
    localparam int PIN_RST_N = 3;
    localparam logic [PIN_W-1:0] PIN_SYNC_RESET = 4'ha;
    // register map
    localparam logic [ADDR_W-1:0] MODE_CTRL_ADDR = 7'h01;
    localparam logic [ADDR_W-1:0] SOFT_CLEAR_ADDR = 7'h04;
    localparam int SOFT_CLEAR_BIT = 0;
    // converter_mode_control fields
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 4;
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 2;
    localparam int GROUP_LSB = 2;
    localparam int GROUP_W = 2;
    localparam int SLEEP_LSB = 4;
    localparam int SLEEP_W = 2;
    localparam int GRAY_BIT = 7;
    localparam int BW_BIT = 8;
    localparam int TEST_BIT = 12;
    localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
    localparam logic [SLEEP_W-1:0] SLEEP_RESET = 2'h0;
    localparam logic GRAY_RESET = 1'b0;
    localparam logic BW_RESET = 1'b0;
    localparam logic TEST_RESET = 1'b0;
    // field encodings
    localparam logic [GROUP_W-1:0] GROUP_FOUR = 2'h0;
    localparam logic [GROUP_W-1:0] GROUP_TWO = 2'h1;
    localparam logic [GROUP_W-1:0] GROUP_ONE = 2'h2;
    localparam logic [SLEEP_W-1:0] SLEEP_ACTIVE = 2'h0;
    localparam logic [SLEEP_W-1:0] SLEEP_AB = 2'h1;
    localparam logic [SLEEP_W-1:0] SLEEP_CD = 2'h2;
    localparam logic [SLEEP_W-1:0] SLEEP_FULL = 2'h3;
    localparam logic [1:0] CORES_ONE = 2'h0;
    localparam logic [1:0] CORES_TWO = 2'h1;
    localparam logic [1:0] CORES_FOUR = 2'h2;
    localparam int CH_N = 4;
    localparam logic [CH_N-1:0] CH_NONE = 4'h0;
    localparam logic [CH_N-1:0] CH_A = 4'h1;
    localparam logic [CH_N-1:0] CH_AB = 4'h3;
    localparam logic [CH_N-1:0] CH_CD = 4'hc;
    localparam logic [CH_N-1:0] CH_ALL = 4'hf;
    typedef enum logic [3:0] {
        FR_IDLE = 4'h1, FR_HEADER = 4'h2, FR_DATA = 4'h4, FR_DONE = 4'h8
    } frame_state_e;
    typedef enum logic [CH_N-1:0] {
        MODE_FOUR = 4'h1, MODE_TWO = 4'h2, MODE_ONE = 4'h4, MODE_COMMON = 4'h8
    } group_mode_e;
endpackage

// >>> rtl/reg_access_if.sv
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
    logic wr_valid;
    logic [mode_ctrl_pkg::ADDR_W-1:0] addr;
    logic [mode_ctrl_pkg::DATA_W-1:0] wdata;
    logic [mode_ctrl_pkg::DATA_W-1:0] rdata;
    logic pin_reset;
    modport link (output wr_valid, output addr, output wdata, output pin_reset, input rdata);
    modport regs (input wr_valid, input addr, input wdata, input pin_reset, output rdata);
endinterface
`default_nettype wire

// >>> rtl/spi_frame_rx.sv
`timescale 1ns/1ps
`default_nettype none
module spi_frame_rx
    import mode_ctrl_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // serial pins, asynchronous to clk_i
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    input wire logic rst_n_i,
    output logic miso_o,
    // register side
    reg_access_if.link bus
);
    logic [PIN_W-1:0] meta_q, meta_d, sync_q, sync_d;
    logic sclk_prev_q, sclk_prev_d;
    frame_state_e state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [FRAME_BITS-1:0] shift_q, shift_d;
    logic [DATA_W-1:0] tx_q, tx_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic miso_q, miso_d, rw_q, rw_d, wr_q, wr_d;
    logic sclk_rise, sclk_fall, selected, mosi_bit;

    // sclk is oversampled: edges show two clk_i cycles late
    always_comb begin
        meta_d = {rst_n_i, mosi_i, cs_n_i, sclk_i};
        sync_d = meta_q;
        sclk_prev_d = sync_q[PIN_SCLK];
        sclk_rise = sync_q[PIN_SCLK] & ~sclk_prev_q;
        sclk_fall = ~sync_q[PIN_SCLK] & sclk_prev_q;
        selected = ~sync_q[PIN_CS_N];
        mosi_bit = sync_q[PIN_MOSI];
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        tx_d = tx_q;
        addr_d = addr_q;
        miso_d = miso_q;
        rw_d = rw_q;
        wr_d = 1'b0;
        case (state_q)
            FR_IDLE: begin
                miso_d = 1'b0;
                cnt_d = CNT_ZERO;
                if (selected) begin
                    state_d = FR_HEADER;
                end
            end
            FR_HEADER, FR_DATA: begin
                if (!selected) begin
                    // short frame is dropped without a write
                    state_d = FR_IDLE;
                end else if (sclk_rise) begin
                    shift_d = {shift_q[FRAME_BITS-2:0], mosi_bit}; // R15
                    cnt_d = cnt_q + CNT_ONE;
                    if (cnt_q == CNT_ZERO) begin
                        rw_d = mosi_bit; // R15
                    end
                    if (cnt_q == HEADER_LAST) begin
                        state_d = FR_DATA;
                        addr_d = {shift_q[ADDR_W-2:0], mosi_bit};
                    end
                    if (cnt_q == FRAME_LAST) begin
                        state_d = FR_DONE;
                    end
                end else if (sclk_fall && state_q == FR_DATA && rw_q == RW_READ) begin
                    if (cnt_q == HEADER_DONE) begin
                        miso_d = bus.rdata[DATA_W-1]; // R15
                        tx_d = {bus.rdata[DATA_W-2:0], 1'b0};
                    end else begin
                        miso_d = tx_q[DATA_W-1]; // R15
                        tx_d = {tx_q[DATA_W-2:0], 1'b0};
                    end
                end
            end
            FR_DONE: begin
                // commit only on deselect, extra clocks are ignored
                if (!selected) begin
                    wr_d = (rw_q == RW_WRITE); // R15
                    state_d = FR_IDLE;
                end
            end
            default: begin
                state_d = FR_IDLE;
            end
        endcase
        if (!sync_q[PIN_RST_N]) begin
            state_d = FR_IDLE;
            miso_d = 1'b0;
            wr_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta_q <= PIN_SYNC_RESET;
            sync_q <= PIN_SYNC_RESET;
            sclk_prev_q <= 1'b0;
            state_q <= FR_IDLE;
            cnt_q <= CNT_ZERO;
            shift_q <= '0;
            tx_q <= '0;
            addr_q <= '0;
            miso_q <= 1'b0;
            rw_q <= RW_READ;
            wr_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            sclk_prev_q <= sclk_prev_d;
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            tx_q <= tx_d;
            addr_q <= addr_d;
            miso_q <= miso_d;
            rw_q <= rw_d;
            wr_q <= wr_d;
        end
    end

    assign bus.wr_valid = wr_q;
    assign bus.addr = addr_q;
    assign bus.wdata = shift_q[DATA_W-1:0];
    assign bus.pin_reset = ~sync_q[PIN_RST_N];
    assign miso_o = miso_q;

    AST_WRITE_NEEDS_FULL_FRAME: // R15
    assert property (@(posedge clk_i) disable iff (reset_i)
        wr_q |-> $past(state_q == FR_DONE) && $past(rw_q) == RW_WRITE)
        else $error("write issued without a complete write frame");

    AST_READ_FRAME_NO_WRITE: // R15
    assert property (@(posedge clk_i) disable iff (reset_i)
        (state_q == FR_DONE && rw_q == RW_READ) |=> !wr_q)
        else $error("read frame produced a register write");
endmodule // spi_frame_rx
`default_nettype wire

// >>> verif/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    // clock
    input wire logic clk_i,
    // serial pins
    input wire logic miso_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o,
    // captured read word and frame end
    output logic [15:0] rdata_o,
    output logic done_o
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
        rdata_o = 16'h0000;
        done_o = 1'b0;
    end
    // phases of 4 clocks so the oversampling front end sees every edge
    task automatic frame(input logic [23:0] f, input int n);
        cs_n_o = 1'b0;
        repeat (4) @(negedge clk_i);
        for (int i = 23; i >= 24 - n; i--) begin
            mosi_o = f[i];
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b1;
            repeat (4) @(negedge clk_i);
            if (i < 16) rdata_o[i] = miso_i;
            sclk_o = 1'b0;
        end
        repeat (4) @(negedge clk_i);
        cs_n_o = 1'b1;
        // released data line must not keep its last level
        mosi_o = ~mosi_o;
        repeat (8) @(negedge clk_i);
        done_o = 1'b1;
        @(negedge clk_i);
        done_o = 1'b0;
    endtask
endmodule // spi_host_model
`default_nettype wire

// >>> verif/test_adc_mode_control_register.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_mode_control_register;
    import mode_ctrl_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic port_rst_n = 1'b1;
    logic sclk, cs_n, mosi, miso, done, gray, bw, test;
    logic [15:0] rdata;
    logic [15:0] cur = 16'h0000;
    logic [3:0] gm, act;
    logic [1:0] route, cores;
    logic [31:0] e;
    logic [31:0] q[$];
    int fail_count = 0;
    int tests_run = 0;
    always #12.5 clk_i = ~clk_i;
    adc_mode_control_register uut (.clk_i(clk_i), .reset_i(reset_i),
        .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
        .serial_port_reset_n_i(port_rst_n), .spi_miso_o(miso), .group_mode_o(gm),
        .route_channel_o(route), .cores_per_channel_o(cores), .channel_active_o(act),
        .gray_code_o(gray), .analog_bandwidth_select_o(bw), .test_pattern_en_o(test));
    spi_host_model host (.clk_i(clk_i), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n),
        .mosi_o(mosi), .rdata_o(rdata), .done_o(done));
    function automatic logic [14:0] decode(input logic [15:0] r);
        logic [3:0] m, a;
        logic [1:0] s;
        m = r[3:0];
        s = r[5:4];
        case (m[3:2])
            2'h0: a = s == 2'h0 ? 4'hf : s == 2'h1 ? 4'hc : s == 2'h2 ? 4'h3 : 4'h0;
            2'h1: a = (s[0] ? 4'h0 : (m[0] ? 4'h2 : 4'h1))
                | (s[1] ? 4'h0 : (m[1] ? 4'h8 : 4'h4));
            2'h2: a = s == 2'h0 ? 4'h1 << m[1:0] : 4'h0;
            default: a = s == 2'h0 ? 4'hf : 4'h0;
        endcase
        return {4'h1 << m[3:2], m[3:2] == 2'h0 ? 2'h0 : m[1:0],
            m[3:2] == 2'h1 ? 2'h1 : m[3:2] == 2'h2 ? 2'h2 : 2'h0,
            a, r[7], r[8], r[12]};
    endfunction
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        if (q.size() != 0) fail_count++;
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // note the expected state first, then run the frame
    task automatic op(input logic rw, input logic [6:0] a, input logic [15:0] d, input int n);
        if (rw && n == 24 && a == 7'h01) cur = d & 16'h11bf;
        if (rw && n == 24 && a == 7'h04 && d[0]) cur = 16'h0000;
        q.push_back({~rw, a == 7'h01 ? cur : 16'h0000, decode(cur)});
        host.frame({rw, a, d}, n);
    endtask
    always @(posedge clk_i) begin
        if (done === 1'b1) begin
            e = q.pop_front();
            if (e[31]) check("rdata", rdata, e[30:15]);
            check("outputs", {gm, route, cores, act, gray, bw, test}, {1'b0, e[14:0]});
            // host owes the alignment pulse pair whenever this reads set
            check("test", {15'h0000, test}, {15'h0000, e[0]});
        end
    end
    initial begin
        logic [15:0] d;
        void'($urandom(80549));
        repeat (20) @(negedge clk_i);
        reset_i = 1'b0;
        repeat (4) @(negedge clk_i);
        op(1'b0, 7'h01, 16'h0000, 24);
        for (int i = 0; i < 64; i++) begin
            d = 16'($urandom()) & 16'hd7ff;
            d[5:0] = i[5:0];
            op(1'b1, 7'h01, d, 24);
            op(1'b0, 7'h01, 16'h0000, 24);
        end
        op(1'b1, 7'h01, 16'h1187, 24);
        op(1'b1, 7'h03, 16'hd7ff, 24);
        op(1'b1, 7'h01, 16'h0000, 20);
        op(1'b0, 7'h02, 16'h0000, 24);
        op(1'b1, 7'h04, 16'h0001, 24);
        op(1'b1, 7'h01, 16'h1187, 24);
        port_rst_n = 1'b0;
        repeat (6) @(negedge clk_i);
        port_rst_n = 1'b1;
        cur = 16'h0000;
        repeat (4) @(negedge clk_i);
        op(1'b0, 7'h01, 16'h0000, 24);
        report_and_stop();
    end
    initial begin
        repeat (100000) @(posedge clk_i);
        fail_count++;
        report_and_stop();
    end
endmodule // test_adc_mode_control_register
`default_nettype wire
